// >>> rcc_defines.vh
// constants for the redriver per-channel configuration register bank
// included by the bank and its memory module; definitions only
`ifndef RCC_DEFINES_VH
`define RCC_DEFINES_VH

`define RCC_OFS_STATUS 5'h00
`define RCC_OFS_EQ_GAIN 5'h01
`define RCC_OFS_PROFILE_FLAT 5'h03
`define RCC_OFS_DET_CTRL 5'h04
`define RCC_OFS_PD_OVR 5'h05
`define RCC_OFS_DET_RST 5'h0A

`define RCC_BASE_BCAST 3'h4
`define RCC_BASE_SHARED 3'h7

`define RCC_RST_STATUS 8'h00
`define RCC_RST_EQ_GAIN 8'h00
`define RCC_RST_PROFILE_FLAT 8'h05
`define RCC_RST_DET_CTRL 8'h00
`define RCC_RST_PD_OVR 8'h7F
`define RCC_RST_DET_RST 8'h00

`define RCC_MASK_PROFILE_FLAT 8'h7F
`define RCC_MASK_DET_CTRL 8'h07
`define RCC_MASK_DET_RST 8'h04
`define RCC_MASK_PD_OVR 8'hFF
`define RCC_MASK_EQ_GAIN 8'hFF

`define RCC_BIT_DET_P 7
`define RCC_BIT_DET_N 6
`define RCC_BIT_SKIP 7
`define RCC_BIT_OVR_EN 7
`define RCC_BIT_FORCE 2
`define RCC_BIT_POLL_EN 1
`define RCC_BIT_POLL_SEL 0
`define RCC_BIT_FSM_RST 2

`define RCC_POLL_TWO 2'h2
`define RCC_POLL_THREE 2'h3
`define RCC_POLL_ONE 2'h1

`define RCC_BLOCK_ALL_OFF 7'h00
`define RCC_BLOCK_ALL_ON 7'h7F
`define RCC_RST_FLAT 3'h5

`endif

// >>> rcc_reg_mem.v
// small register store: one 8-bit word per channel for each of the five writable offsets
// write by channel mask; read data registered, one cycle after the address
`timescale 1ns/1ps
`include "rcc_defines.vh"

module rcc_reg_mem #(
    parameter CHANNELS = 2
) (
    input wire clk_in,
    input wire reset_in,
    input wire [CHANNELS-1:0] wr_mask_in,
    input wire [4:0] wr_ofs_in,
    input wire [7:0] wr_data_in,
    input wire [0:0] rd_chan_in,
    input wire [4:0] rd_ofs_in,
    output reg [7:0] rd_data_out
);
    reg [7:0] eq_reg [0:CHANNELS-1];
    reg [7:0] pf_reg [0:CHANNELS-1];
    reg [7:0] dc_reg [0:CHANNELS-1];
    reg [7:0] pd_reg [0:CHANNELS-1];
    reg [7:0] dr_reg [0:CHANNELS-1];
    genvar g;

    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : chan
            always @(posedge clk_in) begin
                if (reset_in) begin
                    eq_reg[g] <= `RCC_RST_EQ_GAIN;
                    pf_reg[g] <= `RCC_RST_PROFILE_FLAT;
                    dc_reg[g] <= `RCC_RST_DET_CTRL;
                    pd_reg[g] <= `RCC_RST_PD_OVR;
                    dr_reg[g] <= `RCC_RST_DET_RST;
                end else if (wr_mask_in[g]) begin
                    case (wr_ofs_in)
                        `RCC_OFS_EQ_GAIN: eq_reg[g] <= wr_data_in & `RCC_MASK_EQ_GAIN;
                        `RCC_OFS_PROFILE_FLAT: pf_reg[g] <= wr_data_in & `RCC_MASK_PROFILE_FLAT;
                        `RCC_OFS_DET_CTRL: dc_reg[g] <= wr_data_in & `RCC_MASK_DET_CTRL;
                        `RCC_OFS_PD_OVR: pd_reg[g] <= wr_data_in & `RCC_MASK_PD_OVR;
                        `RCC_OFS_DET_RST: dr_reg[g] <= wr_data_in & `RCC_MASK_DET_RST;
                        default: ;
                    endcase
                end
            end
        end
    endgenerate

    always @(posedge clk_in) begin
        if (reset_in) begin
            rd_data_out <= 8'h00;
        end else begin
            case (rd_ofs_in)
                `RCC_OFS_EQ_GAIN: rd_data_out <= eq_reg[rd_chan_in];
                `RCC_OFS_PROFILE_FLAT: rd_data_out <= pf_reg[rd_chan_in];
                `RCC_OFS_DET_CTRL: rd_data_out <= dc_reg[rd_chan_in];
                `RCC_OFS_PD_OVR: rd_data_out <= pd_reg[rd_chan_in];
                `RCC_OFS_DET_RST: rd_data_out <= dr_reg[rd_chan_in];
                default: rd_data_out <= 8'h00;
            endcase
        end
    end
endmodule

// >>> rcc_channel_bank.v
// one bank of two redriver channels: configuration registers, latched
// termination-detect status and per-channel control outputs
// assumes a serial-bus front end that delivers decoded byte reads/writes
// synchronous to CLK_IN, one access per pulse
//
// Contract
// [R1] latched positive-pin detect status in bit 7
// [R2] latched negative-pin detect status in bit 6
// [R3] bit 7 of gain register bypasses stage one
// [R4] stage one boost from bits 6..3
// [R5] stage two boost from bits 2..0
// [R6] midband shape bits 6..3, bit 7 reads zero
// [R7] flat gain bits 2..0, reset 101
// [R8] detect control bit 2 forces termination detected
// [R9] extra polling only when bit 1 set
// [R10] bit 0 picks two or three polls
// [R11] power-down override active only with bit 7
// [R12] override field enables or disables each block
// [R13] base 0x80 writes all, reads first channel
// [R14] detect reset bit 2 holds fsm reset
// [R15] fsm reset clears both latched status bits
`timescale 1ns/1ps
`include "rcc_defines.vh"

module rcc_channel_bank #(
    parameter CHANNELS = 2
) (
    // clock and reset
    input wire CLK_IN,
    input wire RESET_IN,
    // register access from the serial-bus front end
    input wire WR_STB_IN,
    input wire RD_STB_IN,
    input wire [7:0] ADDR_IN,
    input wire [7:0] WDATA_IN,
    output reg [7:0] RDATA_OUT,
    output reg RVALID_OUT,
    // receiver-detect comparator results, one per channel
    input wire [CHANNELS-1:0] TERM_SEEN_P_IN,
    input wire [CHANNELS-1:0] TERM_SEEN_N_IN,
    // per-channel controls, packed channel 0 in the low slice
    output reg [CHANNELS-1:0] FIRST_BOOST_SKIP_OUT,
    output reg [4*CHANNELS-1:0] FIRST_BOOST_LEVEL_OUT,
    output reg [3*CHANNELS-1:0] SECOND_BOOST_LEVEL_OUT,
    output reg [4*CHANNELS-1:0] MIDBAND_BOOST_SHAPE_OUT,
    output reg [3*CHANNELS-1:0] FLAT_GAIN_OUT,
    output reg [CHANNELS-1:0] FORCE_TERM_PRESENT_OUT,
    output reg [CHANNELS-1:0] POLL_EXTRA_EN_OUT,
    output reg [2*CHANNELS-1:0] POLL_COUNT_OUT,
    output reg [CHANNELS-1:0] TERM_DETECT_FSM_RESET_OUT,
    output reg [7*CHANNELS-1:0] BLOCK_EN_OUT
);
    // shadow copies of the writable registers drive the analog controls;
    // the memory module only serves reads
    reg [7:0] eq_reg [0:CHANNELS-1];
    reg [7:0] pf_reg [0:CHANNELS-1];
    reg [7:0] dc_reg [0:CHANNELS-1];
    reg [7:0] pd_reg [0:CHANNELS-1];
    reg [7:0] dr_reg [0:CHANNELS-1];
    reg [CHANNELS-1:0] det_p_reg;
    reg [CHANNELS-1:0] det_n_reg;
    reg rd_pend_reg;
    reg rd_status_reg;
    reg rd_none_reg;
    reg [7:0] status_reg;

    wire [2:0] base = ADDR_IN[7:5];
    wire [4:0] ofs = ADDR_IN[4:0];
    wire [7:0] mem_rdata;
    reg [CHANNELS-1:0] wr_mask;
    reg [0:0] rd_chan;

    // base 0x00/0x20 -> first channel, 0x40/0x60 -> second
    function [0:0] chan_of;
        input [2:0] b;
        begin
            chan_of = b[1];
        end
    endfunction

    function is_chan_base;
        input [2:0] b;
        begin
            is_chan_base = (b < `RCC_BASE_BCAST);
        end
    endfunction

    always @* begin
        wr_mask = {CHANNELS{1'b0}};
        rd_chan = 1'b0;
        if (WR_STB_IN) begin
            if (base == `RCC_BASE_BCAST) begin
                wr_mask = {CHANNELS{1'b1}}; // [R13]
            end else if (is_chan_base(base)) begin
                wr_mask[chan_of(base)] = 1'b1;
            end
        end
        if (is_chan_base(base)) begin
            rd_chan = chan_of(base);
        end // broadcast base reads the first channel [R13]
    end

    rcc_reg_mem #(
        .CHANNELS(CHANNELS)
    ) u_mem (
        .clk_in(CLK_IN),
        .reset_in(RESET_IN),
        .wr_mask_in(wr_mask),
        .wr_ofs_in(ofs),
        .wr_data_in(WDATA_IN),
        .rd_chan_in(rd_chan),
        .rd_ofs_in(ofs),
        .rd_data_out(mem_rdata)
    );

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : chan
            always @(posedge CLK_IN) begin
                if (RESET_IN) begin
                    eq_reg[g] <= `RCC_RST_EQ_GAIN;
                    pf_reg[g] <= `RCC_RST_PROFILE_FLAT; // [R7]
                    dc_reg[g] <= `RCC_RST_DET_CTRL;
                    pd_reg[g] <= `RCC_RST_PD_OVR;
                    dr_reg[g] <= `RCC_RST_DET_RST;
                end else if (wr_mask[g]) begin
                    case (ofs)
                        `RCC_OFS_EQ_GAIN: eq_reg[g] <= WDATA_IN & `RCC_MASK_EQ_GAIN;
                        `RCC_OFS_PROFILE_FLAT: pf_reg[g] <= WDATA_IN & `RCC_MASK_PROFILE_FLAT;
                        `RCC_OFS_DET_CTRL: dc_reg[g] <= WDATA_IN & `RCC_MASK_DET_CTRL;
                        `RCC_OFS_PD_OVR: pd_reg[g] <= WDATA_IN & `RCC_MASK_PD_OVR;
                        `RCC_OFS_DET_RST: dr_reg[g] <= WDATA_IN & `RCC_MASK_DET_RST;
                        default: ;
                    endcase
                end
            end

            // detect flags latch high; fsm reset clears them, but a detection
            // is ignored while the fsm is held so reset wins here
            always @(posedge CLK_IN) begin
                if (RESET_IN) begin
                    det_p_reg[g] <= 1'b0;
                    det_n_reg[g] <= 1'b0;
                end else if (dr_reg[g][`RCC_BIT_FSM_RST]) begin
                    det_p_reg[g] <= 1'b0; // [R15] [R14]
                    det_n_reg[g] <= 1'b0; // [R15]
                end else begin
                    if (TERM_SEEN_P_IN[g] || dc_reg[g][`RCC_BIT_FORCE]) begin
                        det_p_reg[g] <= 1'b1; // [R1] [R8]
                    end
                    if (TERM_SEEN_N_IN[g] || dc_reg[g][`RCC_BIT_FORCE]) begin
                        det_n_reg[g] <= 1'b1; // [R2] [R8]
                    end
                end
            end

            always @(posedge CLK_IN) begin
                if (RESET_IN) begin
                    FIRST_BOOST_SKIP_OUT[g] <= 1'b0;
                    FIRST_BOOST_LEVEL_OUT[4*g+3:4*g] <= 4'h0;
                    SECOND_BOOST_LEVEL_OUT[3*g+2:3*g] <= 3'h0;
                    MIDBAND_BOOST_SHAPE_OUT[4*g+3:4*g] <= 4'h0;
                    FLAT_GAIN_OUT[3*g+2:3*g] <= `RCC_RST_FLAT; // [R7]
                    FORCE_TERM_PRESENT_OUT[g] <= 1'b0;
                    POLL_EXTRA_EN_OUT[g] <= 1'b0;
                    POLL_COUNT_OUT[2*g+1:2*g] <= `RCC_POLL_ONE;
                    TERM_DETECT_FSM_RESET_OUT[g] <= 1'b0;
                    BLOCK_EN_OUT[7*g+6:7*g] <= `RCC_BLOCK_ALL_ON;
                end else begin
                    FIRST_BOOST_SKIP_OUT[g] <= eq_reg[g][`RCC_BIT_SKIP]; // [R3]
                    FIRST_BOOST_LEVEL_OUT[4*g+3:4*g] <= eq_reg[g][6:3]; // [R4]
                    SECOND_BOOST_LEVEL_OUT[3*g+2:3*g] <= eq_reg[g][2:0]; // [R5]
                    MIDBAND_BOOST_SHAPE_OUT[4*g+3:4*g] <= pf_reg[g][6:3]; // [R6]
                    FLAT_GAIN_OUT[3*g+2:3*g] <= pf_reg[g][2:0]; // [R7]
                    FORCE_TERM_PRESENT_OUT[g] <= dc_reg[g][`RCC_BIT_FORCE]; // [R8]
                    POLL_EXTRA_EN_OUT[g] <= dc_reg[g][`RCC_BIT_POLL_EN]; // [R9]
                    // one poll when extra polling is off, else two or three
                    if (!dc_reg[g][`RCC_BIT_POLL_EN]) begin
                        POLL_COUNT_OUT[2*g+1:2*g] <= `RCC_POLL_ONE; // [R9]
                    end else if (dc_reg[g][`RCC_BIT_POLL_SEL]) begin
                        POLL_COUNT_OUT[2*g+1:2*g] <= `RCC_POLL_THREE; // [R10]
                    end else begin
                        POLL_COUNT_OUT[2*g+1:2*g] <= `RCC_POLL_TWO; // [R10]
                    end
                    TERM_DETECT_FSM_RESET_OUT[g] <= dr_reg[g][`RCC_BIT_FSM_RST]; // [R14]
                    // without override every block stays on
                    if (pd_reg[g][`RCC_BIT_OVR_EN]) begin
                        BLOCK_EN_OUT[7*g+6:7*g] <= pd_reg[g][6:0]; // [R11] [R12]
                    end else begin
                        BLOCK_EN_OUT[7*g+6:7*g] <= `RCC_BLOCK_ALL_ON; // [R11]
                    end
                end
            end
        end
    endgenerate

    // status is assembled at the request so the read returns the latch state
    always @(posedge CLK_IN) begin
        if (RESET_IN) begin
            rd_pend_reg <= 1'b0;
            rd_status_reg <= 1'b0;
            rd_none_reg <= 1'b0;
            status_reg <= `RCC_RST_STATUS;
            RDATA_OUT <= 8'h00;
            RVALID_OUT <= 1'b0;
        end else begin
            rd_pend_reg <= RD_STB_IN;
            rd_status_reg <= (ofs == `RCC_OFS_STATUS) && (base <= `RCC_BASE_BCAST);
            // bases above broadcast belong to no channel; the store would
            // otherwise answer with the first channel's word
            rd_none_reg <= (base > `RCC_BASE_BCAST);
            status_reg <= {det_p_reg[rd_chan], det_n_reg[rd_chan], 6'h00}; // [R1] [R2]
            RVALID_OUT <= rd_pend_reg;
            if (rd_pend_reg) begin
                if (rd_none_reg) begin
                    RDATA_OUT <= 8'h00;
                end else begin
                    RDATA_OUT <= rd_status_reg ? status_reg : mem_rdata; // [R13]
                end
            end
        end
    end
endmodule

// >>> rcc_term_src.sv
// comparator model: drives the per-channel detect levels of the far end
// assumes requests change off the rising edge; the level lasts one cycle
`timescale 1ns/1ps
module rcc_term_src (
    input wire clk_in,
    input wire [1:0] p_req_in,
    input wire [1:0] n_req_in,
    output reg [1:0] p_out,
    output reg [1:0] n_out
);
    initial p_out = 2'b00;
    initial n_out = 2'b00;
    // a detection is a short level, so only a true latch keeps it
    always @(posedge clk_in) begin
        p_out <= p_req_in;
        n_out <= n_req_in;
    end
endmodule

// >>> rcc_channel_bank_props.sv
// port assertions for the two-channel register bank
// assumes one access per strobe and the two-edge answer latency
`timescale 1ns/1ps
module rcc_bank_props #(
    parameter CHANNELS = 2
) (
    input wire CLK_IN,
    input wire RESET_IN,
    input wire WR_STB_IN,
    input wire RD_STB_IN,
    input wire [7:0] ADDR_IN,
    input wire [7:0] WDATA_IN,
    input wire RVALID_OUT,
    input wire [CHANNELS-1:0] FIRST_BOOST_SKIP_OUT,
    input wire [4*CHANNELS-1:0] FIRST_BOOST_LEVEL_OUT,
    input wire [3*CHANNELS-1:0] SECOND_BOOST_LEVEL_OUT,
    input wire [4*CHANNELS-1:0] MIDBAND_BOOST_SHAPE_OUT,
    input wire [3*CHANNELS-1:0] FLAT_GAIN_OUT,
    input wire [CHANNELS-1:0] FORCE_TERM_PRESENT_OUT,
    input wire [CHANNELS-1:0] POLL_EXTRA_EN_OUT,
    input wire [2*CHANNELS-1:0] POLL_COUNT_OUT,
    input wire [CHANNELS-1:0] TERM_DETECT_FSM_RESET_OUT,
    input wire [7*CHANNELS-1:0] BLOCK_EN_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);
    read_answer_a: assert property (RD_STB_IN |-> ##2 RVALID_OUT)
        else $error("read not answered two cycles after strobe");
    rvalid_cause_a: assert property (RVALID_OUT |-> $past(RD_STB_IN, 2))
        else $error("read valid without a read strobe");
    skip_bit_a: assert property (WR_STB_IN && ADDR_IN == 8'h01
        |-> ##2 FIRST_BOOST_SKIP_OUT[0] == $past(WDATA_IN[7], 2))
        else $error("stage one bypass not taken from bit 7");
    first_level_a: assert property (WR_STB_IN && ADDR_IN == 8'h21
        |-> ##2 FIRST_BOOST_LEVEL_OUT[3:0] == $past(WDATA_IN[6:3], 2))
        else $error("stage one level wrong");
    bcast_second_a: assert property (WR_STB_IN && ADDR_IN == 8'h81
        |-> ##2 SECOND_BOOST_LEVEL_OUT == {2{$past(WDATA_IN[2:0], 2)}})
        else $error("broadcast stage two level wrong");
    shape_flat_a: assert property (WR_STB_IN && ADDR_IN == 8'h43
        |-> ##2 {MIDBAND_BOOST_SHAPE_OUT[7:4], FLAT_GAIN_OUT[5:3]} == $past(WDATA_IN[6:0], 2))
        else $error("shape or flat gain wrong");
    poll_ctrl_a: assert property (WR_STB_IN && ADDR_IN == 8'h04 |-> ##2
        {FORCE_TERM_PRESENT_OUT[0], POLL_EXTRA_EN_OUT[0], POLL_COUNT_OUT[1:0]} ==
        {$past(WDATA_IN[2:1], 2), $past(WDATA_IN[1], 2) ? {1'b1, $past(WDATA_IN[0], 2)} : 2'b01})
        else $error("detect control outputs wrong");
    pd_ovr_a: assert property (WR_STB_IN && ADDR_IN == 8'h65 |-> ##2
        BLOCK_EN_OUT[13:7] == ($past(WDATA_IN[7], 2) ? $past(WDATA_IN[6:0], 2) : 7'h7F))
        else $error("block enables wrong");
    fsm_reset_a: assert property (WR_STB_IN && ADDR_IN == 8'h0A
        |-> ##2 TERM_DETECT_FSM_RESET_OUT[0] == $past(WDATA_IN[2], 2))
        else $error("detect fsm reset wrong");
    cover property (RVALID_OUT);
    cover property (WR_STB_IN && ADDR_IN == 8'h81);
    cover property (WR_STB_IN && ADDR_IN == 8'h0A && WDATA_IN[2]);
endmodule
bind rcc_channel_bank rcc_bank_props #(.CHANNELS(CHANNELS)) u_props (.CLK_IN(CLK_IN),
    .RESET_IN(RESET_IN), .WR_STB_IN(WR_STB_IN), .RD_STB_IN(RD_STB_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .RVALID_OUT(RVALID_OUT), .FIRST_BOOST_SKIP_OUT(FIRST_BOOST_SKIP_OUT),
    .FIRST_BOOST_LEVEL_OUT(FIRST_BOOST_LEVEL_OUT), .SECOND_BOOST_LEVEL_OUT(SECOND_BOOST_LEVEL_OUT),
    .MIDBAND_BOOST_SHAPE_OUT(MIDBAND_BOOST_SHAPE_OUT), .FLAT_GAIN_OUT(FLAT_GAIN_OUT),
    .FORCE_TERM_PRESENT_OUT(FORCE_TERM_PRESENT_OUT), .POLL_EXTRA_EN_OUT(POLL_EXTRA_EN_OUT),
    .POLL_COUNT_OUT(POLL_COUNT_OUT), .TERM_DETECT_FSM_RESET_OUT(TERM_DETECT_FSM_RESET_OUT),
    .BLOCK_EN_OUT(BLOCK_EN_OUT));

// >>> redriver_channel_config_regs_test.sv
// self-checking bench for the two-channel register bank
// assumes reads answer exactly two edges after the strobe
`timescale 1ns/1ps
module redriver_channel_config_regs_test;
    localparam [63:0] OFFS = 64'h00010203_04050A1F;
    localparam [63:0] DIR = 64'h01218143_04650A00;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg wr = 1'b0;
    reg rd_s = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [7:0] wdat = 8'h00;
    reg [1:0] p_req = 2'b00;
    reg [1:0] n_req = 2'b00;
    wire [1:0] seen_p, seen_n;
    wire [7:0] rdata;
    wire rvalid;
    wire [5:0] flat;
    wire [3:0] poll;
    wire [13:0] blk;
    wire [1:0] skip, frc, pext, fsr;
    wire [7:0] lvl1, shape;
    wire [5:0] lvl2;
    reg [7:0] m [0:1][0:31];
    reg [1:0] sp = 2'b00;
    reg [1:0] sn = 2'b00;
    reg [31:0] seed = 32'h1c439ace;
    integer bad_count = 0;
    integer num_checks = 0;
    integer i, j;
    initial forever #4 clk = ~clk;
    rcc_channel_bank #(.CHANNELS(2)) u_dut (.CLK_IN(clk), .RESET_IN(rst), .WR_STB_IN(wr),
        .RD_STB_IN(rd_s), .ADDR_IN(addr), .WDATA_IN(wdat), .RDATA_OUT(rdata),
        .RVALID_OUT(rvalid), .TERM_SEEN_P_IN(seen_p), .TERM_SEEN_N_IN(seen_n),
        .FIRST_BOOST_SKIP_OUT(skip), .FIRST_BOOST_LEVEL_OUT(lvl1),
        .SECOND_BOOST_LEVEL_OUT(lvl2), .MIDBAND_BOOST_SHAPE_OUT(shape),
        .FLAT_GAIN_OUT(flat), .FORCE_TERM_PRESENT_OUT(frc), .POLL_EXTRA_EN_OUT(pext),
        .POLL_COUNT_OUT(poll), .TERM_DETECT_FSM_RESET_OUT(fsr), .BLOCK_EN_OUT(blk));
    rcc_term_src u_src (.clk_in(clk), .p_req_in(p_req), .n_req_in(n_req), .p_out(seen_p),
        .n_out(seen_n));
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    function [4:0] off(input [2:0] k);
        off = OFFS[(7 - k) * 8 +: 5];
    endfunction
    task chk(input [63:0] what, input [13:0] e, input [13:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                bad_count = bad_count + 1;
                $display("unexpected %0s exp %h got %h", what, e, g);
            end
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", num_checks, bad_count);
            if (bad_count == 0 && num_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task wr_reg(input [7:0] a, input [7:0] d);
        integer c;
        reg [7:0] k;
        reg mp;
        begin
            @(negedge clk);
            wr = 1'b1;
            addr = a;
            wdat = d;
            @(negedge clk);
            wr = 1'b0;
            k = (a[4:0] == 5'h03) ? 8'h7F : (a[4:0] == 5'h04) ? 8'h07 : 8'hFF;
            k = (a[4:0] == 5'h0A) ? 8'h04 : k;
            mp = a[4:0] == 5'h01 || (a[4:0] > 5'h02 && a[4:0] < 5'h06) || a[4:0] == 5'h0A;
            for (c = 0; c < 2; c = c + 1)
                if (mp && (a[7:5] == 3'h4 || (a[7:5] < 3'h4 && a[6] == c[0]))) begin
                    m[c][a[4:0]] = d & k;
                    // fsm reset wins over the forced detection
                    if (m[c][10][2])
                        {sp[c], sn[c]} = 2'b00;
                    else if (m[c][4][2])
                        {sp[c], sn[c]} = 2'b11;
                end
        end
    endtask
    task rd_reg(input [7:0] a);
        reg c;
        reg [7:0] e;
        begin
            c = (a[7:5] < 3'h4) ? a[6] : 1'b0;
            e = (a[4:0] == 5'h00) ? {sp[c], sn[c], 6'h00} : m[c][a[4:0]];
            e = (a[7:5] > 3'h4) ? 8'h00 : e;
            @(negedge clk);
            rd_s = 1'b1;
            addr = a;
            @(negedge clk);
            rd_s = 1'b0;
            // the answer stands between the second and third edge after the strobe
            @(negedge clk);
            chk("rvalid", 14'h0001, {13'h0000, rvalid});
            chk("rdata", {6'h00, e}, {6'h00, rdata});
        end
    endtask
    task det(input [1:0] p, input [1:0] n);
        integer c;
        begin
            @(negedge clk);
            p_req = p;
            n_req = n;
            @(negedge clk);
            p_req = 2'b00;
            n_req = 2'b00;
            repeat (3) @(negedge clk);
            for (c = 0; c < 2; c = c + 1)
                if (!m[c][10][2]) begin
                    sp[c] = sp[c] | p[c];
                    sn[c] = sn[c] | n[c];
                end
        end
    endtask
    task out_chk;
        integer c;
        reg [13:0] eb;
        reg [5:0] ef;
        reg [3:0] ep;
        reg [1:0] es, efo, epx, efr;
        reg [7:0] el1, esh;
        reg [5:0] el2;
        begin
            for (c = 0; c < 2; c = c + 1) begin
                eb[7*c +: 7] = m[c][5][7] ? m[c][5][6:0] : 7'h7F;
                ef[3*c +: 3] = m[c][3][2:0];
                ep[2*c +: 2] = m[c][4][1] ? {1'b1, m[c][4][0]} : 2'b01;
                es[c] = m[c][1][7];
                el1[4*c +: 4] = m[c][1][6:3];
                el2[3*c +: 3] = m[c][1][2:0];
                esh[4*c +: 4] = m[c][3][6:3];
                efo[c] = m[c][4][2];
                epx[c] = m[c][4][1];
                efr[c] = m[c][10][2];
            end
            chk("eq_gain", {4'h0, es, el1}, {4'h0, skip, lvl1});
            chk("shape", {el2, esh}, {lvl2, shape});
            chk("det_ctl", {8'h00, efo, epx, efr}, {8'h00, frc, pext, fsr});
            chk("block_en", eb, blk);
            chk("flat", {8'h00, ef}, {8'h00, flat});
            chk("poll", {10'h000, ep}, {10'h000, poll});
        end
    endtask
    initial begin
        #200000;
        bad_count = bad_count + 1;
        close_out;
    end
    initial begin
        for (i = 0; i < 64; i = i + 1)
            m[i / 32][i % 32] = (i % 32 == 3) ? 8'h05 : (i % 32 == 5) ? 8'h7F : 8'h00;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        out_chk;
        // reset values, unmapped offsets and an unused base
        for (i = 0; i < 8; i = i + 1)
            for (j = 0; j < 8; j = j + 2)
                rd_reg({j[2:0], off(i[2:0])});
        for (i = 0; i < 8; i = i + 1) begin
            seed = xs(seed);
            wr_reg(DIR[(7 - i) * 8 +: 8], seed[7:0]);
            rd_reg(DIR[(7 - i) * 8 +: 8]);
        end
        out_chk;
        wr_reg(8'h8A, 8'h00);
        wr_reg(8'h84, 8'h00);
        det(2'b10, 2'b01);
        rd_reg(8'h40);
        rd_reg(8'h80);
        wr_reg(8'h4A, 8'h04);
        rd_reg(8'h40);
        det(2'b11, 2'b11);
        rd_reg(8'h60);
        rd_reg(8'h00);
        wr_reg(8'h4A, 8'h00);
        wr_reg(8'h24, 8'h04);
        rd_reg(8'h20);
        for (i = 0; i < 40; i = i + 1) begin
            seed = xs(seed);
            j = (seed[10:8] > 3'h4) ? seed[10:8] - 4 : seed[10:8];
            wr_reg({j[2:0], off(seed[13:11])}, seed[31:24]);
            rd_reg({seed[18:16], off(seed[21:19])});
            out_chk;
        end
        close_out;
    end
endmodule
